/* File: design/counter_pkg.sv */
/*
 package of the up/down counter stage and its controller: widths, limits,
 register map of the controller, reset values and timing counts.
 assumes a single system clock of 10 MHz.
*/
package counter_pkg;
	localparam int          COUNT_W         = 4;
	localparam logic [3:0]  DECADE_LAST     = 4'h9;
	localparam logic [3:0]  BINARY_LAST     = 4'hf;
	localparam logic [3:0]  COUNT_ZERO      = 4'h0;

	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam logic [7:0]  CTRL_OFS        = 8'h00;
	localparam logic [7:0]  DIVIDER_OFS     = 8'h04;
	localparam logic [7:0]  PRESET_OFS      = 8'h08;
	localparam logic [7:0]  STATUS_OFS      = 8'h0c;
	localparam logic [7:0]  CARRY_CNT_OFS   = 8'h10;

	localparam int          CTRL_RUN_BIT    = 0;
	localparam int          CTRL_DOWN_BIT   = 1;
	localparam int          ST_TERM_BIT     = 4;
	localparam int          ST_RIPPLE_BIT   = 5;
	localparam int          ST_BUSY_BIT     = 6;
	localparam int          ST_DOWN_BIT     = 7;
	localparam int          ST_EN_N_BIT     = 8;

	localparam logic [1:0]  CTRL_RESET      = 2'h0;
	localparam logic [7:0]  DIVIDER_RESET   = 8'h04;
	localparam logic [3:0]  PRESET_RESET    = 4'h0;
	localparam logic [7:0]  CARRY_CNT_RESET = 8'h00;

	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          PRESET_WIDTH_NS = 35;
	localparam int          RECOVERY_NS     = 40;
	localparam int          PRESET_CYCLES_R = (PRESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RECOVERY_CYC_R  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PRESET_CYCLES   = (PRESET_CYCLES_R < 1) ? 1 : PRESET_CYCLES_R;
	localparam int          RECOVERY_CYCLES = (RECOVERY_CYC_R < 1) ? 1 : RECOVERY_CYC_R;
	localparam logic [3:0]  BUSY_CYCLES     = 4'(PRESET_CYCLES + RECOVERY_CYCLES);
	localparam logic [3:0]  RECOVERY_LEFT   = 4'(RECOVERY_CYCLES);

	function automatic logic is_terminal(input logic [3:0] value,
	                                     input logic       down,
	                                     input logic [3:0] last);
		is_terminal = down ? (value == COUNT_ZERO) : (value == last);
	endfunction
endpackage

/* File: design/counter_if.sv */
/*
 interface joining one counter stage to its controlling logic.
 assumes both ends run on the same system clock; no clock lives here.
*/
`timescale 1ns/1ps
interface counter_if;
	logic       count_pulse_in;
	logic       count_enable_n;
	logic       count_down;
	logic       preset_load_n;
	logic [3:0] preset_data;
	logic [3:0] count_value;
	logic       terminal_reached;
	logic       ripple_clock_n;

	modport device (
		input  count_pulse_in,
		input  count_enable_n,
		input  count_down,
		input  preset_load_n,
		input  preset_data,
		output count_value,
		output terminal_reached,
		output ripple_clock_n
	);

	modport host (
		output count_pulse_in,
		output count_enable_n,
		output count_down,
		output preset_load_n,
		output preset_data,
		input  count_value,
		input  terminal_reached,
		input  ripple_clock_n
	);
endinterface

/* File: design/count_step.sv */
/*
 next count of a four-bit up/down sequence that wraps at both ends.
 assumes value and direction are stable for the cycle.
*/
`timescale 1ns/1ps
module count_step #(
	parameter logic [3:0] LAST = 4'hf
) (
	input  wire logic [3:0] value,
	input  wire logic       down,
	output logic [3:0]      next_value,
	output logic            wraps
);
	import counter_pkg::*;

	always_comb begin
		next_value = value;
		wraps      = 1'b0;
		if (down) begin
			if (value == COUNT_ZERO) begin
				next_value = LAST;    // [RULE_21]
				wraps      = 1'b1;
			end else begin
				next_value = 4'(value - 4'h1);
			end
		end else begin
			// states above LAST only arise from a preset; they also wrap to zero
			if (value >= LAST) begin
				next_value = COUNT_ZERO;    // [RULE_21]
				wraps      = 1'b1;
			end else begin
				next_value = 4'(value + 4'h1);
			end
		end
	end
endmodule

/* File: design/updown_counter_stage.sv */
/*
 one presettable four-bit up/down counter stage, decade or binary by parameter.
 assumes the count pulse and controls come from logic on sys_clk, so they are
 sampled without synchronisers; the count pulse edge is found by sys_clk.
*/
// Notes on behaviour
// [RULE_01] decade variant counts bcd zero to nine
// [RULE_02] binary variant counts zero to fifteen
// [RULE_03] counting only on rising count pulse edge
// [RULE_04] four state bits, variants differ only sequence
// [RULE_05] low preset load copies data asynchronously
// [RULE_06] preset load overrides enable, direction, clock
// [RULE_07] high enable holds, low enable counts
// [RULE_08] direction low counts up, high down
// [RULE_09] enable may drop in either clock state
// [RULE_10] enable rises only while clock high
// [RULE_11] direction changes while enable or clock high
// [RULE_12] terminal high at zero down, maximum up
// [RULE_13] terminal holds until state or direction changes
// [RULE_14] terminal flag must not clock other logic
// [RULE_15] terminal ignores the stage's own enable
// [RULE_16] ripple low: enabled, terminal, clock low
// [RULE_17] ripple returns high as clock rises
// [RULE_18] ripple cascade stops by first stage enable
// [RULE_19] parallel clock low phase covers ripple
// [RULE_20] parallel cascade gates lower terminals plus enable
// [RULE_21] counting wraps at both ends
`timescale 1ns/1ps
module updown_counter_stage #(
	parameter bit DECADE = 1'b0
) (
	input  wire logic  sys_clk,
	input  wire logic  nrst,
	counter_if.device  link,
	output logic       count_event,
	output logic       wrap_event,
	output logic       preset_active
);
	import counter_pkg::*;

	localparam logic [3:0] LAST = DECADE ? DECADE_LAST : BINARY_LAST;    // [RULE_01] [RULE_02]

	if (LAST != DECADE_LAST && LAST != BINARY_LAST) begin : g_bad_last
		$error("count stage: unsupported end value");
	end

	// count pulse edge detection
	logic pulse_prev_reg;
	logic pulse_prev_next;
	logic pulse_rise;

	always_comb begin
		pulse_prev_next = link.count_pulse_in;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			// seen as high, so a pulse already high at release is no edge
			pulse_prev_reg <= 1'b1;
		end else begin
			pulse_prev_reg <= pulse_prev_next;
		end
	end

	assign pulse_rise = link.count_pulse_in & ~pulse_prev_reg;    // [RULE_03]

	// counter state
	logic [3:0] state_reg;
	logic [3:0] state_next;
	logic [3:0] stepped;
	logic       step_wraps;
	logic       advance;

	count_step #(
		.LAST (LAST)
	) u_step (
		.value      (state_reg),
		.down       (link.count_down),
		.next_value (stepped),
		.wraps      (step_wraps)
	);

	// the controller keeps enable and direction steady around the rising
	// pulse edge, so a plain sample at that edge is safe
	assign advance = link.preset_load_n & ~link.count_enable_n & pulse_rise;    // [RULE_07] [RULE_10] [RULE_11]

	always_comb begin
		state_next = state_reg;    // [RULE_04]
		if (!link.preset_load_n) begin
			state_next = link.preset_data;    // [RULE_05] [RULE_06]
		end else if (advance) begin
			state_next = stepped;    // [RULE_03] [RULE_08] [RULE_21]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_reg <= COUNT_ZERO;
		end else begin
			state_reg <= state_next;
		end
	end

	// side events for the user
	logic count_event_reg;
	logic count_event_next;
	logic wrap_event_reg;
	logic wrap_event_next;

	always_comb begin
		count_event_next = advance;
		wrap_event_next  = advance & step_wraps;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			count_event_reg <= 1'b0;
			wrap_event_reg  <= 1'b0;
		end else begin
			count_event_reg <= count_event_next;
			wrap_event_reg  <= wrap_event_next;
		end
	end

	assign count_event   = count_event_reg;
	assign wrap_event    = wrap_event_reg;
	assign preset_active = ~link.preset_load_n;

	// the load path bypasses the flip-flops so the outputs follow the preset
	// data at once, as an asynchronous load would
	assign link.count_value = link.preset_load_n ? state_reg : link.preset_data;    // [RULE_05]

	// decoded from value and direction only; it may glitch, so it is a flag
	// and never a clock for anything downstream
	assign link.terminal_reached = is_terminal(link.count_value, link.count_down, LAST);    // [RULE_12] [RULE_13] [RULE_15]

	// combinational so it rises as soon as the pulse rises
	assign link.ripple_clock_n = ~(~link.count_enable_n & link.terminal_reached
		& ~link.count_pulse_in);    // [RULE_16] [RULE_17]
endmodule

/* File: design/counter_controller.sv */
/*
 controlling end of a counter stage: makes the count pulse by a divider,
 applies enable and direction only at safe moments, runs presets and
 counts ripple pulses. software reaches it by a plain register port.
 assumes the stage runs on the same sys_clk.
*/
`timescale 1ns/1ps
module counter_controller (
	input  wire logic                            sys_clk,
	input  wire logic                            nrst,
	counter_if.host                              link,
	input  wire logic [counter_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [counter_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                            reg_write,
	input  wire logic                            reg_read,
	output logic      [counter_pkg::DATA_W-1:0]  reg_rdata
);
	import counter_pkg::*;

	logic [1:0] ctrl_reg,   ctrl_next;
	logic [7:0] div_reg,    div_next;
	logic [3:0] preset_reg, preset_next;
	logic [7:0] carry_reg,  carry_next;
	logic [7:0] tick_cnt_reg, tick_cnt_next;
	logic       pulse_reg,  pulse_next;
	logic       en_n_reg,   en_n_next;
	logic       down_reg,   down_next;
	logic [3:0] busy_reg,   busy_next;
	logic       ripple_prev_reg, ripple_prev_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic       tick;
	logic       safe_high;
	logic       ripple_fall;

	// a divider of zero acts as one, so a steady high cycle always exists
	assign tick        = (busy_reg == 4'h0) && (tick_cnt_reg >= div_reg)
		&& (tick_cnt_reg != 8'h00);    // [RULE_19]
	assign safe_high   = pulse_reg & ~tick;
	assign ripple_fall = ripple_prev_reg & ~link.ripple_clock_n;

	always_comb begin
		ctrl_next        = ctrl_reg;
		div_next         = div_reg;
		preset_next      = preset_reg;
		carry_next       = carry_reg;
		busy_next        = (busy_reg != 4'h0) ? 4'(busy_reg - 4'h1) : busy_reg;
		tick_cnt_next    = tick ? 8'h00 : 8'(tick_cnt_reg + 8'h01);
		pulse_next       = tick ? ~pulse_reg : pulse_reg;
		en_n_next        = en_n_reg;
		down_next        = down_reg;
		ripple_prev_next = link.ripple_clock_n;
		rdata_next       = '0;
		if (busy_reg != 4'h0) begin
			tick_cnt_next = 8'h00;
		end
		if (reg_write) begin
			case (reg_addr)
				CTRL_OFS: begin
					ctrl_next = reg_wdata[1:0];
				end
				DIVIDER_OFS: begin
					div_next = reg_wdata[7:0];
				end
				PRESET_OFS: begin
					preset_next = reg_wdata[3:0];
					busy_next   = BUSY_CYCLES;
				end
				CARRY_CNT_OFS: begin
					carry_next = CARRY_CNT_RESET;
				end
				default: begin
				end
			endcase
		end
		// a ripple pulse in the clearing cycle still counts
		if (ripple_fall) begin
			carry_next = (reg_write && reg_addr == CARRY_CNT_OFS) ? 8'h01
				: 8'(carry_reg + 8'h01);
		end
		// direction moves only while the stage is inhibited or the pulse is high
		if (ctrl_reg[CTRL_DOWN_BIT] != down_reg && (en_n_reg || safe_high)) begin
			down_next = ctrl_reg[CTRL_DOWN_BIT];    // [RULE_11]
		end
		// enable drops a cycle after the direction settles, never with it
		if (ctrl_reg[CTRL_RUN_BIT] && down_reg == ctrl_reg[CTRL_DOWN_BIT]) begin
			en_n_next = 1'b0;    // [RULE_09]
		end else if (!ctrl_reg[CTRL_RUN_BIT] && safe_high) begin
			en_n_next = 1'b1;    // [RULE_10] [RULE_18]
		end
		if (reg_read) begin
			case (reg_addr)
				CTRL_OFS:      rdata_next = DATA_W'(ctrl_reg);
				DIVIDER_OFS:   rdata_next = DATA_W'(div_reg);
				PRESET_OFS:    rdata_next = DATA_W'(preset_reg);
				STATUS_OFS: begin
					rdata_next[3:0]           = link.count_value;
					rdata_next[ST_TERM_BIT]   = link.terminal_reached;    // [RULE_14]
					rdata_next[ST_RIPPLE_BIT] = link.ripple_clock_n;
					rdata_next[ST_BUSY_BIT]   = (busy_reg != 4'h0);
					rdata_next[ST_DOWN_BIT]   = down_reg;
					rdata_next[ST_EN_N_BIT]   = en_n_reg;
				end
				CARRY_CNT_OFS: rdata_next = DATA_W'(carry_reg);
				default:       rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_reg        <= CTRL_RESET;
			div_reg         <= DIVIDER_RESET;
			preset_reg      <= PRESET_RESET;
			carry_reg       <= CARRY_CNT_RESET;
			tick_cnt_reg    <= 8'h00;
			pulse_reg       <= 1'b0;
			en_n_reg        <= 1'b1;
			down_reg        <= 1'b0;
			busy_reg        <= 4'h0;
			ripple_prev_reg <= 1'b1;
			rdata_reg       <= '0;
		end else begin
			ctrl_reg        <= ctrl_next;
			div_reg         <= div_next;
			preset_reg      <= preset_next;
			carry_reg       <= carry_next;
			tick_cnt_reg    <= tick_cnt_next;
			pulse_reg       <= pulse_next;
			en_n_reg        <= en_n_next;
			down_reg        <= down_next;
			busy_reg        <= busy_next;
			ripple_prev_reg <= ripple_prev_next;
			rdata_reg       <= rdata_next;
		end
	end

	// load is low for the first part of busy; the rest is recovery before a pulse
	assign link.preset_load_n  = ~(busy_reg > RECOVERY_LEFT);
	assign link.preset_data    = preset_reg;
	assign link.count_pulse_in = pulse_reg;
	assign link.count_enable_n = en_n_reg;
	assign link.count_down     = down_reg;
	assign reg_rdata           = rdata_reg;
endmodule

/* File: tb/presettable_updown_counter_sva.sv */
/*
 assertions on the link between the controller and the binary counter stage.
 assumes every link signal is sampled on sys_clk, with nrst synchronous active low.
*/
`timescale 1ns/1ps
module presettable_updown_counter_sva (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       count_pulse_in,
	input  wire logic       count_enable_n,
	input  wire logic       count_down,
	input  wire logic       preset_load_n,
	input  wire logic [3:0] preset_data,
	input  wire logic [3:0] count_value,
	input  wire logic       terminal_reached,
	input  wire logic       ripple_clock_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence counting_edge;
		preset_load_n && !count_enable_n && $rose(count_pulse_in);
	endsequence

	chk_preset_copy: assert property (!preset_load_n |-> count_value == preset_data)
		else $error("count outputs do not follow preset data");
	chk_edge_only: assert property (
		(preset_load_n && !$rose(count_pulse_in)) ##1 preset_load_n |-> $stable(count_value))
		else $error("count changed without a rising count pulse");
	chk_enable_hold: assert property (
		(preset_load_n && count_enable_n) ##1 preset_load_n |-> $stable(count_value))
		else $error("count changed while disabled");
	chk_step_up: assert property (
		(counting_edge and !count_down) ##1 preset_load_n
		|-> count_value == 4'($past(count_value) + 4'h1))
		else $error("up step wrong");
	chk_step_down: assert property (
		(counting_edge and count_down) ##1 preset_load_n
		|-> count_value == 4'($past(count_value) - 4'h1))
		else $error("down step wrong");
	chk_terminal_decode: assert property (
		terminal_reached == (count_down ? count_value == 4'h0 : count_value == 4'hf))
		else $error("terminal flag wrong");
	chk_ripple_level: assert property (
		ripple_clock_n == !(!count_enable_n && !count_pulse_in
		&& (count_down ? count_value == 4'h0 : count_value == 4'hf)))
		else $error("ripple output wrong");
	chk_ripple_return: assert property ($rose(count_pulse_in) |-> ripple_clock_n)
		else $error("ripple low after count pulse rose");
	chk_inhibit_timing: assert property (
		$rose(count_enable_n) |-> count_pulse_in && $past(count_pulse_in))
		else $error("enable raised while count pulse low");
	chk_direction_timing: assert property (
		$changed(count_down) |-> count_enable_n || count_pulse_in)
		else $error("direction changed while enabled and pulse low");

	cover property ((counting_edge and !count_down) ##0 count_value == 4'hf);
	cover property ((counting_edge and count_down) ##0 count_value == 4'h0);
	cover property (!ripple_clock_n);
	cover property (!preset_load_n);
endmodule

/* File: tb/presettable_updown_counter_test.sv */
/*
 self-checking bench: controller drives a binary stage through its registers,
 and the bench drives a decade stage directly on a second link.
 assumes one 10 MHz sys_clk; expectations come from the bench's own functions.
*/
`timescale 1ns/1ps
`define CHK(what, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s expected %0h seen %0h", what, e, g); end end
module presettable_updown_counter_test;
	import counter_pkg::*;
	logic        sys_clk, nrst, reg_write, reg_read, count_event, wrap_event, preset_active;
	logic        count_event_b, wrap_event_b, preset_active_b, dir_a, d;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [3:0]  exp_a, exp_b, v;
	int          n_fail, checks_done, cycles, seed, wraps;
	counter_if link_a();
	counter_if link_b();
	counter_controller u_counter_controller (.sys_clk(sys_clk), .nrst(nrst), .link(link_a),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata));
	updown_counter_stage #(.DECADE(1'b0)) u_updown_counter_stage (.sys_clk(sys_clk),
		.nrst(nrst), .link(link_a), .count_event(count_event), .wrap_event(wrap_event),
		.preset_active(preset_active));
	updown_counter_stage #(.DECADE(1'b1)) u_updown_counter_stage_dec (.sys_clk(sys_clk),
		.nrst(nrst), .link(link_b), .count_event(count_event_b), .wrap_event(wrap_event_b),
		.preset_active(preset_active_b));
	presettable_updown_counter_sva u_presettable_updown_counter_sva (.sys_clk(sys_clk),
		.nrst(nrst), .count_pulse_in(link_a.count_pulse_in),
		.count_enable_n(link_a.count_enable_n), .count_down(link_a.count_down),
		.preset_load_n(link_a.preset_load_n), .preset_data(link_a.preset_data),
		.count_value(link_a.count_value), .terminal_reached(link_a.terminal_reached),
		.ripple_clock_n(link_a.ripple_clock_n));

	always #50 sys_clk = ~sys_clk;

	function automatic logic [3:0] step(input logic [3:0] sv, input logic sd, input logic [3:0] last);
		if (sd) step = (sv == COUNT_ZERO) ? last : sv - 4'h1;
		else step = (sv >= last) ? COUNT_ZERO : sv + 4'h1;
	endfunction
	function automatic logic [31:0] status_of(input logic [3:0] sv, input logic sd);
		status_of = {23'h0, 1'b1, sd, 1'b0, 1'b1, sd ? sv == COUNT_ZERO : sv == BINARY_LAST, sv};
	endfunction

	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= wd;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		@(negedge sys_clk);
		rd = reg_rdata;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
		reg_rd(a);
		`CHK(what, e, rd)
	endtask
	// polling keeps the bench independent of the controller's exact latencies
	task automatic poll_bit(input int pos, input logic val);
		for (int i = 0; i < 40; i++) begin
			reg_rd(STATUS_OFS);
			if (rd[pos] === val) break;
		end
	endtask
	// entered just after a rising sys_clk edge with the decade count pulse high
	task automatic tick_b(input logic en_n, input logic sd);
		logic term_exp;
		logic wrap_exp;
		link_b.count_enable_n <= en_n;
		link_b.count_down <= sd;
		term_exp = sd ? exp_b == COUNT_ZERO : exp_b == DECADE_LAST;
		wrap_exp = !en_n && (sd ? exp_b == COUNT_ZERO : exp_b >= DECADE_LAST);
		@(posedge sys_clk) link_b.count_pulse_in <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		`CHK("decade terminal", term_exp, link_b.terminal_reached)
		`CHK("decade ripple", !(!en_n && term_exp), link_b.ripple_clock_n)
		@(posedge sys_clk) link_b.count_pulse_in <= 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		if (!en_n) exp_b = step(exp_b, sd, DECADE_LAST);
		`CHK("decade value", exp_b, link_b.count_value)
		`CHK("decade count flag", !en_n, count_event_b)
		`CHK("decade wrap flag", wrap_exp, wrap_event_b)
		@(posedge sys_clk);
	endtask

	always @(negedge sys_clk) begin
		if (nrst && count_event === 1'b1) begin
			if (exp_a == (dir_a ? COUNT_ZERO : BINARY_LAST)) wraps++;
			`CHK("wrap flag", exp_a == (dir_a ? COUNT_ZERO : BINARY_LAST), wrap_event)
			exp_a = step(exp_a, dir_a, BINARY_LAST);
			`CHK("binary value", exp_a, link_a.count_value)
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		{reg_addr, reg_wdata, reg_write, reg_read} = '0;
		{link_b.count_pulse_in, link_b.count_down, link_b.preset_data} = '0;
		{link_b.count_enable_n, link_b.preset_load_n} = 2'h3;
		{n_fail, checks_done, cycles, wraps} = '0;
		seed = 44707;
		{exp_a, exp_b, dir_a} = '0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_chk("ctrl reset", CTRL_OFS, 32'h0);
		rd_chk("divider reset", DIVIDER_OFS, {24'h0, DIVIDER_RESET});
		rd_chk("carry reset", CARRY_CNT_OFS, 32'h0);
		rd_chk("status reset", STATUS_OFS, status_of(4'h0, 1'b0));
		reg_wr(8'h14, 32'hffff_ffff);
		rd_chk("unmapped", 8'h14, 32'h0);
		$display("test registers done");
		for (int p = 0; p < 4; p++) begin
			v = (p == 3) ? 4'($random(seed)) : (p == 0) ? 4'he : (p == 1) ? 4'h1 : 4'hf;
			d = p[0];
			reg_wr(DIVIDER_OFS, 32'(($random(seed) & 3) + 1));
			reg_wr(CTRL_OFS, {30'h0, d, 1'b0});
			rd_chk("turned status", STATUS_OFS, status_of(exp_a, d));
			reg_wr(PRESET_OFS, {28'h0, v});
			@(negedge sys_clk);
			`CHK("binary load flag", 1'b1, preset_active)
			`CHK("binary async load", v, link_a.count_value)
			poll_bit(ST_BUSY_BIT, 1'b0);
			exp_a = v;
			dir_a = d;
			rd_chk("preset status", STATUS_OFS, status_of(v, d));
			reg_wr(CTRL_OFS, {30'h0, d, 1'b1});
			repeat (60) @(posedge sys_clk);
			reg_wr(CTRL_OFS, {30'h0, d, 1'b0});
			poll_bit(ST_EN_N_BIT, 1'b1);
			rd_chk("stopped status", STATUS_OFS, status_of(exp_a, d));
			$display("test binary run %0d done", p);
		end
		rd_chk("carry count", CARRY_CNT_OFS, 32'(wraps));
		reg_wr(CARRY_CNT_OFS, 32'h0);
		rd_chk("carry cleared", CARRY_CNT_OFS, 32'h0);
		$display("test carries done");
		// count pulse rises during the load and must be ignored
		@(posedge sys_clk);
		link_b.preset_load_n <= 1'b0;
		link_b.preset_data <= 4'h7;
		link_b.count_enable_n <= 1'b0;
		@(posedge sys_clk) link_b.count_pulse_in <= 1'b1;
		@(negedge sys_clk);
		`CHK("load flag", 1'b1, preset_active_b)
		@(posedge sys_clk) link_b.preset_data <= 4'h8;
		@(negedge sys_clk);
		`CHK("async load", 4'h8, link_b.count_value)
		@(posedge sys_clk) link_b.preset_load_n <= 1'b1;
		exp_b = 4'h8;
		for (int i = 0; i < 16; i++) begin
			tick_b(i == 9 || i == 14, (i < 4) ? 1'b0 : (i < 8) ? 1'b1 : 1'($random(seed)));
		end
		// a preset above nine is left by counting up to zero
		@(posedge sys_clk) link_b.preset_load_n <= 1'b0;
		link_b.preset_data <= 4'hd;
		@(posedge sys_clk) link_b.preset_load_n <= 1'b1;
		exp_b = 4'hd;
		tick_b(1'b0, 1'b0);
		$display("test decade done");
		tally_and_finish();
	end
endmodule
